/* crc_pkg.sv */
// Constants shared by the cache region control block
package crc_pkg;

    // ****************************************
    // Bus and address geometry
    // ****************************************
    localparam int PADDR_W = 18;
    localparam int IDX_W = PADDR_W - 2;
    localparam int ADDR_W = 20;
    localparam int ALIGN_W = 3;
    localparam int HIGH_LSB = 16;
    localparam int NUM_NC = 4;
    localparam int NUM_RANGE = NUM_NC + 1;
    localparam int WI_RANGE = NUM_NC;

    // ****************************************
    // Register indices (byte address is four times the index)
    // ****************************************
    localparam logic [IDX_W-1:0] IDX_CTRL = 16'h0000;
    localparam logic [IDX_W-1:0] IDX_NC0_START_LOW = 16'hfec2;
    localparam logic [IDX_W-1:0] IDX_NC0_START_HIGH = 16'hfec4;
    localparam logic [IDX_W-1:0] IDX_NC0_END_LOW = 16'hfec6;
    localparam logic [IDX_W-1:0] IDX_NC0_END_HIGH = 16'hfec8;
    localparam logic [IDX_W-1:0] IDX_NC1_START_LOW = 16'hfeca;
    localparam logic [IDX_W-1:0] IDX_NC1_START_HIGH = 16'hfecc;
    localparam logic [IDX_W-1:0] IDX_NC1_END_LOW = 16'hfece;
    localparam logic [IDX_W-1:0] IDX_NC1_END_HIGH = 16'hfed0;
    localparam logic [IDX_W-1:0] IDX_NC2_START_LOW = 16'hfed2;
    localparam logic [IDX_W-1:0] IDX_NC2_START_HIGH = 16'hfed4;
    localparam logic [IDX_W-1:0] IDX_NC2_END_LOW = 16'hfed6;
    localparam logic [IDX_W-1:0] IDX_NC2_END_HIGH = 16'hfed8;
    localparam logic [IDX_W-1:0] IDX_NC3_START_LOW = 16'hfeda;
    localparam logic [IDX_W-1:0] IDX_NC3_START_HIGH = 16'hfedc;
    localparam logic [IDX_W-1:0] IDX_NC3_END_LOW = 16'hfede;
    localparam logic [IDX_W-1:0] IDX_NC3_END_HIGH = 16'hfee0;
    localparam logic [IDX_W-1:0] IDX_WI_START_LOW = 16'hfee2;
    localparam logic [IDX_W-1:0] IDX_WI_START_HIGH = 16'hfee4;
    localparam logic [IDX_W-1:0] IDX_WI_END_LOW = 16'hfee6;
    localparam logic [IDX_W-1:0] IDX_WI_END_HIGH = 16'hfee8;
    localparam int RANGE_STRIDE_LOG2 = 3;

    // Sub-register within one range block
    localparam logic [1:0] SUB_START_LOW = 2'h0;
    localparam logic [1:0] SUB_START_HIGH = 2'h1;
    localparam logic [1:0] SUB_END_LOW = 2'h2;
    localparam logic [1:0] SUB_END_HIGH = 2'h3;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int CTRL_W = 16;
    localparam int ICACHE_ON_BIT = 15;
    localparam int DCACHE_ON_BIT = 14;
    localparam int NC_LSB = 8;
    localparam int WINV_ON_BIT = 7;
    localparam logic [CTRL_W-1:0] CTRL_WR_MASK = 16'hcf80;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
    localparam logic [ADDR_W-1:ALIGN_W] ADDR_RESET = 17'h00000;

endpackage

/* crc_top.sv */
// Cache control and region decode with an APB register slave
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
// How it works
// RULE1 - The instruction cache is on exactly while control bit 15 is one.
// RULE2 - The data cache is on exactly while control bit 14 is one.
// RULE3 - Control bits 8 to 11 enable non-cacheable regions zero to three in order.
// RULE4 - The write-invalidate range is active only while control bit 7 is one.
// RULE5 - Control bits 13 to 12 and 6 to 0 are reserved, read zero and ignore writes.
// RULE6 - Each region start address takes bits 15..3 from its low and 19..16 from its high register.
// RULE7 - Region start address bits 2..0 are always zero and ignore writes.
// RULE8 - Each region end address takes bits 15..3 from its low and 19..16 from its high register.
// RULE9 - Region end address bits 2..0 are always zero and read-only.
// RULE10 - The write-invalidate start address is built from low bits 15..3 and high bits 3..0.
// RULE11 - The write-invalidate end address is built the same way as a 20-bit value.
// RULE12 - Write-invalidate address bits 2..0 are fixed zero so the range is 8-byte aligned.
// RULE13 - An access inside any enabled non-cacheable region, inclusive, bypasses both caches.
// RULE14 - A data write inside the enabled write-invalidate range, inclusive, invalidates its line while the data cache is on.
module crc_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [crc_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic acc_instr,
    input wire logic [crc_pkg::ADDR_W-1:0] acc_addr,
    output logic instr_cache_on,
    output logic data_cache_on,
    output logic acc_done,
    output logic acc_cacheable,
    output logic acc_invalidate
);
    import crc_pkg::*;

    // ****************************************
    // Decode helpers
    // ****************************************
    typedef struct packed
    {
        logic hit;
        logic [2:0] range;
        logic [1:0] sub;
    } crc_dec_t;

    function automatic crc_dec_t crc_decode(input logic [PADDR_W-1:0] a);
        logic [IDX_W-1:0] idx;
        logic [IDX_W-1:0] diff;
        crc_dec_t d;
        idx = a[PADDR_W-1:2];
        diff = idx - IDX_NC0_START_LOW;
        d.hit = (a[1:0] == 2'h0) && (idx >= IDX_NC0_START_LOW) && (idx <= IDX_WI_END_HIGH)
            && !diff[0];
        d.range = diff[5:3];
        d.sub = diff[2:1];
        return d;
    endfunction

    function automatic logic crc_is_ctrl(input logic [PADDR_W-1:0] a);
        return (a[1:0] == 2'h0) && (a[PADDR_W-1:2] == IDX_CTRL);
    endfunction

    // Inclusive window test on 8-byte aligned limits
    function automatic logic crc_in_range(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:ALIGN_W] lo,
        input logic [ADDR_W-1:ALIGN_W] hi
    );
        logic [ADDR_W-1:0] lo_full;
        logic [ADDR_W-1:0] hi_full;
        lo_full = {lo, {ALIGN_W{1'b0}}};
        hi_full = {hi, {ALIGN_W{1'b0}}};
        return (a >= lo_full) && (a <= hi_full);
    endfunction

    // ****************************************
    // Register storage
    // ****************************************
    logic [CTRL_W-1:0] ctrl_q;
    logic [CTRL_W-1:0] ctrl_d;
    logic [HIGH_LSB-1:ALIGN_W] start_low_q [NUM_RANGE];
    logic [ADDR_W-1:HIGH_LSB] start_high_q [NUM_RANGE];
    logic [HIGH_LSB-1:ALIGN_W] end_low_q [NUM_RANGE];
    logic [ADDR_W-1:HIGH_LSB] end_high_q [NUM_RANGE];
    logic [ADDR_W-1:ALIGN_W] start_addr [NUM_RANGE];
    logic [ADDR_W-1:ALIGN_W] end_addr [NUM_RANGE];
    logic [HIGH_LSB-1:ALIGN_W] wr_low;
    logic [ADDR_W-1:HIGH_LSB] wr_high;
    logic [31:0] rdata_d;
    logic mapped_d;
    logic access_phase;
    logic answer_d;
    logic wr_fire;
    logic ctrl_sel;
    crc_dec_t dec;

    assign dec = crc_decode(paddr);
    assign ctrl_sel = crc_is_ctrl(paddr);
    assign wr_low = pwdata[HIGH_LSB-1:ALIGN_W];
    assign wr_high = pwdata[ADDR_W-HIGH_LSB-1:0];
    // Second access cycle answers; the pready term keeps it to one pulse
    assign access_phase = psel && penable;
    assign answer_d = access_phase && !pready;
    assign wr_fire = access_phase && pready && pwrite;

    // ****************************************
    // APB handshake: one wait state per access
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
        end
        else
        begin
            pready <= answer_d;
        end
    end

    // Unmapped or misaligned address answers with an error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pslverr <= 1'b0;
        end
        else
        begin
            pslverr <= answer_d && !mapped_d;
        end
    end

    // Read data stands only in the answer cycle of a read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
        end
        else if (answer_d && !pwrite)
        begin
            prdata <= rdata_d;
        end
        else
        begin
            prdata <= 32'h00000000;
        end
    end

    // ****************************************
    // Control register and cache enables
    // ****************************************
    // Reserved control bits never store
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_fire && ctrl_sel)
        begin
            ctrl_d = pwdata[CTRL_W-1:0] & CTRL_WR_MASK; // RULE5
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= CTRL_RESET;
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    // Cache enables follow the control register at the same edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            instr_cache_on <= 1'b0;
        end
        else
        begin
            instr_cache_on <= ctrl_d[ICACHE_ON_BIT]; // RULE1
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_cache_on <= 1'b0;
        end
        else
        begin
            data_cache_on <= ctrl_d[DCACHE_ON_BIT]; // RULE2
        end
    end

    // ****************************************
    // Range address storage
    // ****************************************
    // Range address halves; bits 2..0 are not stored
    for (genvar r = 0; r < NUM_RANGE; r++)
    begin : g_range
        logic sel;

        assign sel = wr_fire && dec.hit && (dec.range == 3'(r));
        assign start_addr[r] = {start_high_q[r], start_low_q[r]}; // RULE6 RULE10
        assign end_addr[r] = {end_high_q[r], end_low_q[r]}; // RULE8 RULE11

        // Start address, low half
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                start_low_q[r] <= ADDR_RESET[HIGH_LSB-1:ALIGN_W];
            end
            else if (sel && (dec.sub == SUB_START_LOW))
            begin
                start_low_q[r] <= wr_low; // RULE6 RULE7 RULE10 RULE12
            end
        end

        // Start address, high half
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                start_high_q[r] <= ADDR_RESET[ADDR_W-1:HIGH_LSB];
            end
            else if (sel && (dec.sub == SUB_START_HIGH))
            begin
                start_high_q[r] <= wr_high; // RULE6 RULE10
            end
        end

        // End address, low half
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                end_low_q[r] <= ADDR_RESET[HIGH_LSB-1:ALIGN_W];
            end
            else if (sel && (dec.sub == SUB_END_LOW))
            begin
                end_low_q[r] <= wr_low; // RULE8 RULE9 RULE11 RULE12
            end
        end

        // End address, high half
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                end_high_q[r] <= ADDR_RESET[ADDR_W-1:HIGH_LSB];
            end
            else if (sel && (dec.sub == SUB_END_HIGH))
            begin
                end_high_q[r] <= wr_high; // RULE8 RULE11
            end
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    always_comb
    begin
        rdata_d = 32'h00000000;
        mapped_d = 1'b1;
        if (ctrl_sel)
        begin
            rdata_d[CTRL_W-1:0] = ctrl_q; // RULE5
        end
        else if (dec.hit)
        begin
            unique case (dec.sub)
                SUB_START_LOW:
                begin
                    rdata_d[HIGH_LSB-1:ALIGN_W] = start_low_q[dec.range]; // RULE7
                end
                SUB_START_HIGH:
                begin
                    rdata_d[ADDR_W-HIGH_LSB-1:0] = start_high_q[dec.range]; // RULE6
                end
                SUB_END_LOW:
                begin
                    rdata_d[HIGH_LSB-1:ALIGN_W] = end_low_q[dec.range]; // RULE9
                end
                SUB_END_HIGH:
                begin
                    rdata_d[ADDR_W-HIGH_LSB-1:0] = end_high_q[dec.range]; // RULE8
                end
            endcase
        end
        else
        begin
            mapped_d = 1'b0;
        end
    end

    // ****************************************
    // Access lookup, one cycle of latency
    // ****************************************
    logic [NUM_NC-1:0] nc_hit;
    logic wi_hit;
    logic use_cache;
    logic cacheable_d;
    logic invalidate_d;

    for (genvar r = 0; r < NUM_NC; r++)
    begin : g_nc
        assign nc_hit[r] = ctrl_q[NC_LSB+r] // RULE3
            && crc_in_range(acc_addr, start_addr[r], end_addr[r]); // RULE13
    end

    assign wi_hit = ctrl_q[WINV_ON_BIT] // RULE4
        && crc_in_range(acc_addr, start_addr[WI_RANGE], end_addr[WI_RANGE]);

    // Fetches use the instruction cache, all else the data cache
    always_comb
    begin
        use_cache = acc_instr ? ctrl_q[ICACHE_ON_BIT] : ctrl_q[DCACHE_ON_BIT]; // RULE1 RULE2
        cacheable_d = acc_valid && use_cache && !(|nc_hit); // RULE13
        invalidate_d = acc_valid && acc_write && !acc_instr
            && ctrl_q[DCACHE_ON_BIT] && wi_hit; // RULE14
    end

    // ****************************************
    // Lookup results
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_done <= 1'b0;
        end
        else
        begin
            acc_done <= acc_valid;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_cacheable <= 1'b0;
        end
        else
        begin
            acc_cacheable <= cacheable_d; // RULE13
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_invalidate <= 1'b0;
        end
        else
        begin
            acc_invalidate <= invalidate_d; // RULE14
        end
    end

endmodule

/* crc_monitor.sv */
// Port assertions for the cache region control block
`timescale 1ns/1ps
module crc_monitor
import crc_pkg::*;
(
    input wire logic pclk, presetn, psel, penable, pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic pready, pslverr, acc_valid, acc_write, acc_instr,
    input wire logic instr_cache_on, data_cache_on, acc_done, acc_cacheable, acc_invalidate
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed read of a mapped register
    wire rdok = psel && penable && pready && !pwrite && !pslverr;
    icache_match_a: assert property (rdok && paddr == 0 |-> prdata[15] == instr_cache_on)
        else $error("icache enable differs from control bit");
    dcache_match_a: assert property (rdok && paddr == 0 |-> prdata[14] == data_cache_on)
        else $error("dcache enable differs from control bit");
    ctrl_rsvd_a: assert property (rdok && paddr == 0 |-> (prdata & 32'hffff307f) == 0)
        else $error("reserved control bits not zero");
    low_align_a: assert property (rdok && paddr[3] |-> (prdata & 32'hffff0007) == 0)
        else $error("low address register alignment bits not zero");
    high_rsvd_a: assert property (rdok && paddr != 0 && !paddr[3] |-> prdata[31:4] == 0)
        else $error("high address register reserved bits not zero");
    done_next_a: assert property (acc_valid |=> acc_done)
        else $error("lookup not answered");
    idle_quiet_a: assert property (!acc_valid |=> !acc_done && !acc_cacheable && !acc_invalidate)
        else $error("lookup result without access");
    cache_gate_a: assert property (acc_cacheable
        |-> ($past(acc_instr) ? $past(instr_cache_on) : $past(data_cache_on)))
        else $error("cacheable while that cache is off");
    inval_gate_a: assert property (acc_invalidate |-> $past(acc_valid) && $past(acc_write)
        && !$past(acc_instr) && $past(data_cache_on))
        else $error("invalidate without data write");
endmodule

/* crc_core_model.sv */
// Processor access path model that issues lookups
`timescale 1ns/1ps
module crc_core_model
(
    input wire logic pclk, presetn, req, req_write, req_instr,
    input wire logic [19:0] req_addr,
    output logic acc_valid, acc_write, acc_instr,
    output logic [19:0] acc_addr
);
    // Fields scramble between accesses
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_valid <= 1'b0;
            acc_write <= 1'b0;
            acc_instr <= 1'b0;
            acc_addr <= 20'h00000;
        end
        else
        begin
            acc_valid <= req;
            acc_write <= req ? req_write : ~acc_write;
            acc_instr <= req ? req_instr : ~acc_instr;
            acc_addr <= req ? req_addr : ~acc_addr;
        end
    end
endmodule

/* test_cache_region_control.sv */
// Self-checking testbench for the cache region control block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end
module test_cache_region_control;
    import crc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, req = 0;
    logic req_write = 0, req_instr = 0, pready, pslverr, err;
    logic [PADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, rnd = 32'hf300dd41;
    logic [19:0] req_addr = '0, acc_addr;
    logic acc_valid, acc_write, acc_instr, instr_cache_on, data_cache_on;
    logic acc_done, acc_cacheable, acc_invalidate;
    int error_cnt = 0, n_checks = 0, ctl = 0;
    int m[int];
    always #50 pclk = ~pclk;
    crc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .acc_valid, .acc_write, .acc_instr, .acc_addr,
        .instr_cache_on, .data_cache_on, .acc_done, .acc_cacheable, .acc_invalidate);
    crc_core_model core (.pclk, .presetn, .req, .req_write, .req_instr, .req_addr,
        .acc_valid, .acc_write, .acc_instr, .acc_addr);
    function automatic logic [31:0] nx(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Range limit: o 0 is start, 4 is end
    function automatic int lim(int r, int o);
        int b = 'hfec2 + 8 * r + o;
        return m[b + 2] << 16 | m[b];
    endfunction
    function automatic logic hit(int r, logic [19:0] a);
        return lim(r, 0) <= a && a <= lim(r, 4);
    endfunction
    task automatic print_verdict();
        if (error_cnt == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic apb(input logic w, input int idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= PADDR_W'(idx * 4);
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (w && idx == 0)
            ctl = d & 'hcf80;
        else if (w)
            m[idx] = d & (idx % 4 == 2 ? 'hfff8 : 'hf);
    endtask
    task automatic probe(input logic [19:0] a);
        logic nc = 0;
        rnd = nx(rnd);
        @(posedge pclk);
        req <= 1;
        req_addr <= a;
        req_write <= rnd[0];
        req_instr <= rnd[1];
        @(posedge pclk);
        req <= 0;
        @(posedge pclk);
        #1;
        for (int r = 0; r < 4; r++)
            nc |= ctl[8 + r] && hit(r, a);
        `CHK(acc_done, 1'b1)
        `CHK(acc_cacheable, !nc && ctl[rnd[1] ? 15 : 14])
        `CHK(acc_invalidate, rnd[0] && !rnd[1] && ctl[14] && ctl[7] && hit(4, a))
    endtask
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        apb(0, 0, 0);
        `CHK(rd, 32'h0)
        apb(0, 1, 0);
        `CHK(err, 1'b1)
        for (int k = 0; k < 4; k++)
        begin
            rnd = nx(rnd);
            apb(1, 0, rnd | (k[0] ? 32'hcf80 : 32'h0));
            apb(0, 0, 0);
            `CHK(rd, 32'(ctl))
            `CHK(instr_cache_on, ctl[15])
            `CHK(data_cache_on, ctl[14])
            for (int i = 'hfec2; i <= 'hfee8; i += 2)
            begin
                rnd = nx(rnd);
                apb(1, i, rnd);
                apb(0, i, 0);
                `CHK(rd, 32'(m[i]))
            end
            for (int r = 0; r < 5; r++)
            begin
                probe(20'(lim(r, 0) - 8));
                probe(20'(lim(r, 0)));
                probe(20'(lim(r, 4)));
                probe(20'(lim(r, 4) + 8));
                probe(rnd[19:0]);
            end
        end
        print_verdict();
    end
    initial
    begin
        repeat (8000) @(posedge pclk);
        error_cnt++;
        print_verdict();
    end
endmodule
bind crc_top crc_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .acc_valid, .acc_write, .acc_instr, .instr_cache_on,
    .data_cache_on, .acc_done, .acc_cacheable, .acc_invalidate);
